// ==== rtl/aas_accum_add_adc.sv ====
// Accumulator add instructions and conversion start, with APB register access
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps

// Nibble adder, instanced once for each of the three add instructions
module aas_nib_adder
    import aas_pkg::*;
(
    input  wire logic [NIB_W-1:0]      a,          // Accumulator operand
    input  wire logic [NIB_W-1:0]      b,          // Memory or immediate operand
    input  wire logic                  cin,        // Carry in
    output logic      [NIB_W:0]        sum         // Carry out in the top bit
);

    assign sum = {1'b0, a} + {1'b0, b} + {{NIB_W{1'b0}}, cin};

endmodule : aas_nib_adder

// Sticky flag: an event in the clearing cycle wins, so no event is lost
module aas_sticky_flag
    import aas_pkg::*;
(
    input  wire logic                  clk,        // System clock
    input  wire logic                  rst,        // Synchronous reset, high
    input  wire logic                  setEvt,     // Event that sets the flag
    input  wire logic                  clrReq,     // Request that clears the flag
    output logic                       flag        // Current flag value
);

    logic                    flag_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (setEvt) begin
            flag_q <= 1'b1;
        end else if (clrReq) begin
            flag_q <= 1'b0;
        end
    end

    assign flag = flag_q;

endmodule : aas_sticky_flag

module aas_accum_add_adc
    import aas_pkg::*;
(
    input  wire logic                  clk,        // 50 MHz system clock
    input  wire logic                  rst,        // Synchronous reset, high
    input  wire logic                  psel,       // APB select
    input  wire logic                  penable,    // APB access phase
    input  wire logic                  pwrite,     // APB write
    input  wire logic [ADDR_W-1:0]     paddr,      // APB byte address
    input  wire logic [DATA_W-1:0]     pwdata,     // APB write data
    output logic      [DATA_W-1:0]     prdata,     // APB read data
    output logic                       pready,     // APB ready
    output logic                       pslverr,    // APB error
    input  wire logic                  adcDoneIn,  // Converter finished pulse
    output aas_adc_cmd_t               adcCmd,     // Start pulses to converter
    output logic                       skipNext,   // Next instruction skipped
    output logic                       irq         // Level interrupt
);

    aas_apb_req_t            req;
    logic                    setupRd;
    logic                    accessWr;
    logic                    accessRd;
    logic                    mapped;
    logic                    execInstr;
    logic [INSTR_W-1:0]      instr;
    logic                    isAdcStart;
    logic                    isAddMem;
    logic                    isAddMemCy;
    logic                    isAddImm;
    logic                    isBad;
    logic [NIB_W:0]          sumImm;
    logic [NIB_W:0]          sumMem;
    logic [NIB_W:0]          sumMemCy;
    logic [NIB_W-1:0]        memWord;

    logic [NIB_W-1:0]        acc_q;
    logic                    carryFlag_q;
    logic [DP_W-1:0]         dataPointer_q;
    logic [NIB_W-1:0]        mem_q [MEM_DEPTH];
    logic [NIB_W-1:0]        adcControlReg_q;
    logic                    adcDoneFlag_q;
    logic                    skip_q;
    logic [INSTR_W-1:0]      lastInstr_q;
    aas_adc_cmd_t            adcCmd_q;
    logic [IRQ_W-1:0]        irqStat_q;
    logic [IRQ_W-1:0]        irqStat_d;
    logic [IRQ_W-1:0]        irqMask_q;
    logic [IRQ_W-1:0]        irqEvt;
    logic [DATA_W-1:0]       rdata_d;
    logic [DATA_W-1:0]       rdata_q;
    logic                    err_q;

    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

    // Zero wait states: the access phase always completes
    assign pready = 1'b1;
    assign setupRd = psel && !penable;
    assign accessWr = psel && penable && req.write;
    assign accessRd = psel && penable && !req.write;

    always_comb begin
        unique case (req.addr)
            OFS_INSTR, OFS_ACC, OFS_DPTR, OFS_MEM,
            OFS_ADCCTL, OFS_STATUS, OFS_IRQSTAT, OFS_IRQMASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Instruction decode
    assign instr = req.wdata[INSTR_W-1:0];
    assign execInstr = accessWr && (req.addr == OFS_INSTR);
    assign isAdcStart = (instr == OP_ADC_START);
    assign isAddMem = (instr == OP_ADD_MEM);
    assign isAddMemCy = (instr == OP_ADD_MEM_CY);
    assign isAddImm = (instr[INSTR_W-1:NIB_W] == OP_ADD_IMM_HI);
    assign isBad = !(isAdcStart || isAddMem || isAddMemCy || isAddImm);

    assign memWord = mem_q[dataPointer_q];
    // One adder per instruction, so each result stands ready at the write
    aas_nib_adder immAdd_u (
        .a   (acc_q),
        .b   (instr[NIB_W-1:0]),
        .cin (1'b0),
        .sum (sumImm)
    );

    aas_nib_adder memAdd_u (
        .a   (acc_q),
        .b   (memWord),
        .cin (1'b0),
        .sum (sumMem)
    );

    aas_nib_adder memCyAdd_u (
        .a   (acc_q),
        .b   (memWord),
        .cin (carryFlag_q),
        .sum (sumMemCy)
    );

    // Accumulator
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= RST_NIB;
        end else if (execInstr && isAddImm) begin
            acc_q <= sumImm[NIB_W-1:0];
        end else if (execInstr && isAddMem) begin
            acc_q <= sumMem[NIB_W-1:0];
        end else if (execInstr && isAddMemCy) begin
            acc_q <= sumMemCy[NIB_W-1:0];
        end else if (accessWr && req.addr == OFS_ACC) begin
            acc_q <= req.wdata[NIB_W-1:0];
        end
    end

    // Carry flag: only add-with-carry and an accumulator register write change it
    always_ff @(posedge clk) begin
        if (rst) begin
            carryFlag_q <= 1'b0;
        end else if (execInstr && isAddMemCy) begin
            carryFlag_q <= sumMemCy[NIB_W];
        end else if (accessWr && req.addr == OFS_ACC) begin
            carryFlag_q <= req.wdata[ACC_CARRY_BIT];
        end
    end

    // Skip request from add-immediate
    always_ff @(posedge clk) begin
        if (rst) begin
            skip_q <= 1'b0;
        end else if (execInstr) begin
            skip_q <= isAddImm && !sumImm[NIB_W];
        end
    end
    assign skipNext = skip_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            lastInstr_q <= '0;
        end else if (execInstr) begin
            lastInstr_q <= instr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dataPointer_q <= RST_DP;
        end else if (accessWr && req.addr == OFS_DPTR) begin
            dataPointer_q <= req.wdata[DP_W-1:0];
        end
    end

    // Data memory has no reset; software loads it before use
    always_ff @(posedge clk) begin
        if (accessWr && req.addr == OFS_MEM) begin
            mem_q[dataPointer_q] <= req.wdata[NIB_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            adcControlReg_q <= RST_NIB;
        end else if (accessWr && req.addr == OFS_ADCCTL) begin
            adcControlReg_q <= req.wdata[NIB_W-1:0];
        end
    end

    // Completion: a finish in the start cycle wins over the clear
    aas_sticky_flag doneFlag_u (
        .clk    (clk),
        .rst    (rst),
        .setEvt (adcDoneIn),
        .clrReq (execInstr && isAdcStart),
        .flag   (adcDoneFlag_q)
    );

    // Start pulses, one cycle after the instruction
    always_ff @(posedge clk) begin
        if (rst) begin
            adcCmd_q <= '0;
        end else begin
            adcCmd_q.convStart <= execInstr && isAdcStart
                && !adcControlReg_q[ADC_MODE_BIT];
            adcCmd_q.cmpStart <= execInstr && isAdcStart
                && adcControlReg_q[ADC_MODE_BIT];
        end
    end
    assign adcCmd = adcCmd_q;

    // Interrupt events
    always_comb begin
        irqEvt = '0;
        irqEvt[IRQ_DONE_BIT] = adcDoneIn;
        irqEvt[IRQ_SKIP_BIT] = execInstr && isAddImm && !sumImm[NIB_W];
        irqEvt[IRQ_BAD_BIT] = execInstr && isBad;
    end

    // Read clears the status; an event in the same cycle survives
    always_comb begin
        irqStat_d = irqStat_q;
        if (accessRd && req.addr == OFS_IRQSTAT) begin
            irqStat_d = RST_IRQ;
        end
        irqStat_d = irqStat_d | irqEvt;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irqStat_q <= RST_IRQ;
        end else begin
            irqStat_q <= irqStat_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irqMask_q <= RST_IRQ;
        end else if (accessWr && req.addr == OFS_IRQMASK) begin
            irqMask_q <= req.wdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irqStat_q & irqMask_q);

    // Read data captured in the setup cycle so it comes from a flop
    always_comb begin
        rdata_d = '0;
        unique case (req.addr)
            OFS_INSTR: rdata_d[INSTR_W-1:0] = lastInstr_q;
            OFS_ACC: rdata_d[ACC_CARRY_BIT:0] = {carryFlag_q, acc_q};
            OFS_DPTR: rdata_d[DP_W-1:0] = dataPointer_q;
            OFS_MEM: rdata_d[NIB_W-1:0] = memWord;
            OFS_ADCCTL: rdata_d[NIB_W-1:0] = adcControlReg_q;
            OFS_STATUS: begin
                rdata_d[ST_DONE_BIT] = adcDoneFlag_q;
                rdata_d[ST_SKIP_BIT] = skip_q;
            end
            OFS_IRQSTAT: rdata_d[IRQ_W-1:0] = irqStat_q;
            OFS_IRQMASK: rdata_d[IRQ_W-1:0] = irqMask_q;
            default: rdata_d = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
            err_q <= 1'b0;
        end else if (setupRd) begin
            rdata_q <= rdata_d;
            err_q <= !mapped;
        end else if (psel && !penable) begin
            rdata_q <= '0;
            err_q <= !mapped;
        end
    end

    assign prdata = rdata_q;
    assign pslverr = err_q && psel && penable;

endmodule : aas_accum_add_adc

// ==== rtl/aas_pkg.sv ====
// Constants and types for the accumulator add and conversion start block
// Operation
// - Conversion start clears the done flag; mode bit 0 starts a conversion.
// - Mode bit 1 starts a comparator operation instead, still clearing the flag.
// - The mode bit is bit 3 of the converter control register.
// - Add-memory adds the addressed memory word into the accumulator; carry kept.
// - Add-with-carry sums accumulator, memory word and carry; carry out to carry flag.
package aas_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int INSTR_W = 10;
    localparam int NIB_W = 4;
    localparam int DP_W = 8;
    localparam int MEM_DEPTH = 256;

    // Register byte offsets
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_ACC = 8'h04;
    localparam logic [7:0] OFS_DPTR = 8'h08;
    localparam logic [7:0] OFS_MEM = 8'h0C;
    localparam logic [7:0] OFS_ADCCTL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQSTAT = 8'h18;
    localparam logic [7:0] OFS_IRQMASK = 8'h1C;

    // Field positions
    localparam int ACC_CARRY_BIT = 4;
    localparam int ADC_MODE_BIT = 3;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_SKIP_BIT = 1;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_SKIP_BIT = 1;
    localparam int IRQ_BAD_BIT = 2;
    localparam int IRQ_W = 3;

    // Instruction words
    localparam logic [9:0] OP_ADC_START = 10'h29F;
    localparam logic [9:0] OP_ADD_MEM = 10'h00A;
    localparam logic [9:0] OP_ADD_MEM_CY = 10'h00B;
    localparam logic [5:0] OP_ADD_IMM_HI = 6'h06;

    // Reset values
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [7:0] RST_DP = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

    typedef struct packed {
        logic convStart;
        logic cmpStart;
    } aas_adc_cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic [DATA_W-1:0] wdata;
    } aas_apb_req_t;

endpackage : aas_pkg

// ==== verif/aas_adc_model.sv ====
// Converter model: one finished pulse a fixed time after each start
`timescale 1ns/1ps
module aas_adc_model
    import aas_pkg::*;
#(
    parameter int DLY = 30
) (
    input  wire logic         clk,     // Clock
    input  wire logic         rst,     // Reset
    input  wire aas_adc_cmd_t cmd,     // Starts
    output logic              doneOut, // Finished
    output int                convCnt, // Conversions
    output int                cmpCnt   // Comparisons
);
    int cnt;
    always_ff @(posedge clk) begin
        doneOut <= 1'b0;
        if (rst) begin
            cnt     <= 0;
            convCnt <= 0;
            cmpCnt  <= 0;
        end else if (cmd != '0) begin
            cnt     <= DLY;
            convCnt <= convCnt + 32'(cmd.convStart);
            cmpCnt  <= cmpCnt + 32'(cmd.cmpStart);
        end else if (cnt != 0) begin
            cnt     <= cnt - 1;
            doneOut <= cnt == 1;
        end
    end
endmodule : aas_adc_model

// ==== verif/aas_check_monitor.sv ====
// Checker for start pulses and skip flag
`timescale 1ns/1ps
module aas_check_monitor
    import aas_pkg::*;
(
    input wire logic              clk,     // Clock
    input wire logic              rst,     // Reset
    input wire logic              psel,    // Select
    input wire logic              penable, // Access
    input wire logic              pwrite,  // Write
    input wire logic [ADDR_W-1:0] paddr,   // Address
    input wire logic [DATA_W-1:0] pwdata,  // Write data
    input wire aas_adc_cmd_t      adcCmd,  // Starts
    input wire logic              skipNext // Skip flag
);
    logic modeSel_q, instrWr, startWr, addWr;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    assign instrWr = psel && penable && pwrite && paddr == OFS_INSTR;
    assign startWr = instrWr && pwdata[9:0] == OP_ADC_START;
    assign addWr = instrWr && pwdata[9:1] == OP_ADD_MEM[9:1];
    // Shadow of the mode bit, so steering can be judged from outside
    always_ff @(posedge clk) begin
        if (rst) begin
            modeSel_q <= 1'b0;
        end else if (psel && penable && pwrite && paddr == OFS_ADCCTL) begin
            modeSel_q <= pwdata[ADC_MODE_BIT];
        end
    end
    start_decode_a: assert property (startWr |=> $onehot(adcCmd))
        else $error("no single start pulse");
    start_pulse_a: assert property (adcCmd != '0 |=> adcCmd == '0)
        else $error("start pulse too long");
    start_cause_a: assert property (adcCmd != '0 |-> $past(startWr))
        else $error("start without start word");
    conv_mode_a: assert property (startWr && !modeSel_q |=> adcCmd.convStart)
        else $error("mode 0 gave no conversion");
    cmp_mode_a: assert property (startWr && modeSel_q |=> adcCmd.cmpStart)
        else $error("mode 1 gave no comparison");
    skip_clear_a: assert property (addWr || startWr |=> !skipNext)
        else $error("skip flag left set");
    skip_hold_a: assert property (!instrWr |=> $stable(skipNext))
        else $error("skip flag moved alone");
endmodule : aas_check_monitor
bind aas_accum_add_adc aas_check_monitor chk_u (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .adcCmd, .skipNext);

// ==== verif/tb_top.sv ====
// Bench for the accumulator add and conversion start block
`timescale 1ns/1ps
module tb_top
    import aas_pkg::*;
;
    localparam int DLY = 30;
    logic         clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rdQ;
    logic         pready, pslverr, errQ, adcDoneIn, skipNext, irq;
    aas_adc_cmd_t adcCmd;
    int           convCnt, cmpCnt, cycles = 0, bad_count = 0, samples_checked = 0;
    always #10 clk = ~clk;
    aas_accum_add_adc dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .adcDoneIn, .adcCmd, .skipNext, .irq);
    aas_adc_model #(.DLY(DLY)) adc_u (.clk, .rst, .cmd(adcCmd), .doneOut(adcDoneIn),
        .convCnt, .cmpCnt);
    task automatic stop_test;
        $display("checks %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdQ = prdata;
        errQ = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rdQ, exp);
    endtask : rdc
    task automatic ex(input logic [9:0] op);
        xfer(1'b1, OFS_INSTR, {22'h0, op});
    endtask : ex
    task automatic irqc(input logic exp);
        @(negedge clk);
        check({31'h0, irq}, {31'h0, exp});
    endtask : irqc
    task automatic imm(input logic [4:0] a, input logic [3:0] n, input logic [4:0] e,
                       input logic s);
        xfer(1'b1, OFS_ACC, {27'h0, a});
        ex({OP_ADD_IMM_HI, n});
        rdc(OFS_ACC, {27'h0, e});
        rdc(OFS_STATUS, {30'h0, s, 1'b0});
        check({31'h0, skipNext}, {31'h0, s});
    endtask : imm
    task automatic arith(input logic [9:0] op, input logic [4:0] a, input logic [3:0] m,
                         input logic [4:0] e);
        // Decoy word at another address catches a pointer that is ignored
        xfer(1'b1, OFS_DPTR, 32'h5A);
        xfer(1'b1, OFS_MEM, {28'h0, ~m});
        xfer(1'b1, OFS_DPTR, 32'hA5);
        xfer(1'b1, OFS_MEM, {28'h0, m});
        xfer(1'b1, OFS_ACC, {27'h0, a});
        ex(op);
        rdc(OFS_ACC, {27'h0, e});
        rdc(OFS_STATUS, 32'h0);
        check({31'h0, skipNext}, 32'h0);
    endtask : arith
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(OFS_ACC, 32'h0);
        rdc(8'h20, 32'h0);
        check({31'h0, errQ}, 32'h1);
        imm(5'h15, 4'h3, 5'h18, 1'b1);
        imm(5'h0E, 4'h3, 5'h01, 1'b0);
        imm(5'h1F, 4'hF, 5'h1E, 1'b0);
        imm(5'h00, 4'hF, 5'h0F, 1'b1);
        arith(OP_ADD_MEM, 5'h19, 4'h8, 5'h11);
        arith(OP_ADD_MEM, 5'h09, 4'h8, 5'h01);
        arith(OP_ADD_MEM_CY, 5'h1F, 4'hF, 5'h1F);
        arith(OP_ADD_MEM_CY, 5'h07, 4'h8, 5'h0F);
        arith(OP_ADD_MEM_CY, 5'h18, 4'h7, 5'h10);
        rdc(OFS_IRQSTAT, 32'h2);
        $display("add tests done");
        for (int m = 0; m < 2; m++) begin
            xfer(1'b1, OFS_ADCCTL, m ? 32'h8 : 32'h7);
            ex(OP_ADC_START);
            rdc(OFS_STATUS, 32'h0);
            repeat (DLY + 8) @(posedge clk);
            check(32'(cmpCnt), 32'(m));
            check(32'(convCnt), 32'h1);
            rdc(OFS_STATUS, 32'h1);
        end
        irqc(1'b0);
        xfer(1'b1, OFS_IRQMASK, 32'h1);
        irqc(1'b1);
        rdc(OFS_IRQSTAT, 32'h1);
        irqc(1'b0);
        ex(10'h3FF);
        rdc(OFS_IRQSTAT, 32'h4);
        $display("converter and interrupt tests done");
        stop_test();
    end
endmodule : tb_top
